// *** core/bps_pkg.sv ***
`default_nettype none

package bps_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int MAG_TIMEOUT_US = 50;
    localparam int MAG_TIMEOUT_CYC = MAG_TIMEOUT_US * CLK_MHZ;
    localparam int VREC_TIMEOUT_US = 4;
    localparam int VREC_TIMEOUT_CYC = VREC_TIMEOUT_US * CLK_MHZ;
    localparam int CNT_W = 16;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_ONTIME = 8'h08;
    localparam logic [7:0] ADDR_MINOFF = 8'h0C;
    localparam logic [7:0] ADDR_MINPER = 8'h10;
    localparam logic [7:0] ADDR_BLANK = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ctrl field positions
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_SS_DONE_BIT = 1;

    // register reset values
    localparam logic [CNT_W-1:0] ONTIME_MAX_RST = 16'h00C8;
    localparam logic [CNT_W-1:0] MINOFF_RST = 16'h0064;
    localparam logic [CNT_W-1:0] MINPER_RST = 16'h0190;
    localparam logic [CNT_W-1:0] BLANK_RST = 16'h003C;

    // ------------------------------------------------------------
    // comparator bundle
    // ------------------------------------------------------------
    typedef struct packed {
        logic aux_below_demag;
        logic aux_top;
        logic cs_above_ocr;
        logic cs_above_ss_max;
        logic cs_above_soft_stop;
        logic mains_below_uvp;
        logic mains_above_start;
        logic boost_above_ovp;
        logic boost_above_scp;
        logic comp_at_zero;
        logic out_below_burst;
    } bps_cmp_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_ON = 4'b0010,
        ST_DEMAG = 4'b0100,
        ST_VALLEY = 4'b1000
    } bps_state_t;

endpackage : bps_pkg

`default_nettype wire

// *** core/bps_sequencer.sv ***
// How it works
// RULE1 - gate stays off while aux winding is below demag threshold
// RULE2 - once aux rises above threshold, hunt valleys with gate still off
// RULE3 - no magnetization within 50 us after gate falls forces turn-on
// RULE4 - aux winding top during valley hunt turns gate on
// RULE5 - no top within 4 us after demag forces turn-on
// RULE6 - period never below the cap; waits on later valley instead
// RULE7 - gate stays off at least the minimum off-time every cycle
// RULE8 - soft-start source on at start-up, off when start-up done
// RULE9 - soft-start source turned back on for soft stop before halting
// RULE10 - charge current limited once current sense exceeds max soft-start voltage
// RULE11 - soft-stop level sampled only during off-time
// RULE12 - sampled level above soft-stop threshold stops switching
// RULE13 - on-time ends when current sense reaches overcurrent level
// RULE14 - overcurrent comparator ignored during blanking after turn-on
// RULE15 - mains undervoltage stops switching at once
// RULE16 - restart after undervoltage only above the start threshold
// RULE17 - boost overvoltage inhibits switching, resumes when it clears
// RULE18 - no switching until boost sense exceeds short-circuit level
// RULE19 - on-time from compensation; zero at zero on-time level
// RULE20 - output below burst level suspends; resume uses soft start (code turns the soft-start source on but keeps switching)
// RULE21 - comparators synchronized; all times counted in clock cycles
// RULE22 - turn-on only when every protection gate allows it
`default_nettype none

module bps_sequencer
    import bps_pkg::*;
#(
    parameter int MAG_TO_CYC = MAG_TIMEOUT_CYC,
    parameter int VREC_TO_CYC = VREC_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // comparator results
    input wire bps_cmp_t cmp_in,
    input wire logic [CNT_W-1:0] loop_compensation,
    // gate and soft-start source
    output logic boost_gate_out,
    output logic soft_start_src_on,
    output logic soft_start_limit,
    // axi4-lite slave
    input wire logic [7:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [7:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);

    // ------------------------------------------------------------
    // input synchronizers
    // ------------------------------------------------------------
    bps_cmp_t sync1_reg;
    bps_cmp_t cmp;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= '0;
            cmp <= '0;
        end else begin
            sync1_reg <= cmp_in; // RULE21
            cmp <= sync1_reg; // RULE21
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [1:0] ctrl_reg;
    logic [CNT_W-1:0] ontime_max_reg;
    logic [CNT_W-1:0] minoff_reg;
    logic [CNT_W-1:0] minper_reg;
    logic [CNT_W-1:0] blank_reg;

    // ------------------------------------------------------------
    // protection gates
    // ------------------------------------------------------------
    logic uvp_reg;
    logic scp_ok_reg;
    logic burst_reg;
    logic stopped_reg;
    logic ss_active_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            uvp_reg <= 1'b1;
            scp_ok_reg <= 1'b0;
            burst_reg <= 1'b0;
        end else begin
            if (cmp.mains_below_uvp)
                uvp_reg <= 1'b1; // RULE15
            else if (cmp.mains_above_start)
                uvp_reg <= 1'b0; // RULE16
            scp_ok_reg <= cmp.boost_above_scp; // RULE18
            burst_reg <= cmp.out_below_burst; // RULE20
        end
    end

    wire enable = ctrl_reg[CTRL_ENABLE_BIT];
    // the soft-stop latch blocks new starts until the stop level drops while enabled and not in burst
    wire gates_ok = enable && !uvp_reg && !cmp.mains_below_uvp && !cmp.boost_above_ovp
        && scp_ok_reg && !stopped_reg; // RULE17 RULE22
    wire halt_req = burst_reg || !enable;

    // ------------------------------------------------------------
    // switch state machine
    // ------------------------------------------------------------
    bps_state_t state_reg, state_next;
    logic [CNT_W-1:0] on_cnt_reg;
    logic [CNT_W-1:0] off_cnt_reg;
    logic [CNT_W-1:0] per_cnt_reg;
    logic [CNT_W-1:0] to_cnt_reg;
    logic mag_seen_reg;

    wire [CNT_W-1:0] on_target = (loop_compensation >= ontime_max_reg) ? 16'h0000 :
        CNT_W'(ontime_max_reg - loop_compensation); // RULE19
    wire off_ok = (off_cnt_reg >= minoff_reg) && (per_cnt_reg >= minper_reg); // RULE6 RULE7
    wire blanked = on_cnt_reg < blank_reg;
    wire ocr_hit = cmp.cs_above_ocr && !blanked; // RULE13 RULE14
    wire on_done = ocr_hit || (on_cnt_reg >= on_target) || cmp.comp_at_zero; // RULE19
    wire mag_to = to_cnt_reg >= CNT_W'(MAG_TO_CYC);
    wire vrec_to = to_cnt_reg >= CNT_W'(VREC_TO_CYC);
    // an early top is dropped: valley hunting continues until the period cap clears
    wire want_on = (state_reg == ST_VALLEY && (cmp.aux_top || vrec_to)) ||
        (state_reg == ST_DEMAG && mag_to && !mag_seen_reg &&
        !cmp.aux_below_demag); // RULE3 RULE4 RULE5
    wire turn_on = want_on && off_ok && gates_ok && !cmp.comp_at_zero; // RULE22

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (gates_ok && off_ok && !cmp.comp_at_zero && !cmp.aux_below_demag) // RULE1
                    state_next = ST_ON;
            end
            ST_ON: begin
                if (on_done || !gates_ok)
                    state_next = ST_DEMAG;
            end
            ST_DEMAG: begin
                if (!gates_ok)
                    state_next = ST_IDLE;
                else if (turn_on)
                    state_next = ST_ON;
                else if (!cmp.aux_below_demag && mag_seen_reg)
                    state_next = ST_VALLEY; // RULE1 RULE2
            end
            ST_VALLEY: begin
                if (!gates_ok)
                    state_next = ST_IDLE;
                else if (turn_on)
                    state_next = ST_ON;
                else if (cmp.aux_below_demag)
                    state_next = ST_DEMAG; // RULE1
            end
            default: state_next = ST_IDLE;
        endcase
    end

    // demag waits for magnetization first; timeout counter restarts on entry to demag from on-time and on entry to valley
    wire entering = state_next != state_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            on_cnt_reg <= '0;
            off_cnt_reg <= '0;
            per_cnt_reg <= '0;
            to_cnt_reg <= '0;
            mag_seen_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            on_cnt_reg <= (state_next == ST_ON && state_reg == ST_ON) ?
                CNT_W'(on_cnt_reg + 16'h0001) : '0;
            off_cnt_reg <= (state_next == ST_ON) ? '0 :
                (off_cnt_reg == 16'hFFFF ? off_cnt_reg : CNT_W'(off_cnt_reg + 16'h0001));
            per_cnt_reg <= (state_next == ST_ON && state_reg != ST_ON) ? '0 :
                (per_cnt_reg == 16'hFFFF ? per_cnt_reg : CNT_W'(per_cnt_reg + 16'h0001));
            if (state_reg == ST_ON && state_next == ST_DEMAG)
                mag_seen_reg <= 1'b0;
            else if (cmp.aux_below_demag)
                mag_seen_reg <= 1'b1;
            if (entering && state_next == ST_DEMAG && state_reg == ST_ON)
                to_cnt_reg <= 16'h0001; // RULE3
            else if (entering && state_next == ST_VALLEY)
                to_cnt_reg <= '0; // RULE5
            else if (state_reg == ST_DEMAG && cmp.aux_below_demag && !mag_seen_reg)
                to_cnt_reg <= 16'h0001;
            else if (to_cnt_reg != 16'hFFFF)
                to_cnt_reg <= CNT_W'(to_cnt_reg + 16'h0001);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            boost_gate_out <= 1'b0;
        else
            boost_gate_out <= (state_next == ST_ON); // RULE1 RULE7
    end

    // ------------------------------------------------------------
    // soft start and soft stop
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ss_active_reg <= 1'b1;
            stopped_reg <= 1'b0;
        end else begin
            if (ctrl_reg[CTRL_SS_DONE_BIT] && !halt_req && !stopped_reg)
                ss_active_reg <= 1'b0; // RULE8
            else if (halt_req)
                ss_active_reg <= 1'b1; // RULE9
            // sampled only while gate is off, on-time spikes would trip it
            if (!boost_gate_out && cmp.cs_above_soft_stop)
                stopped_reg <= 1'b1; // RULE11 RULE12
            else if (!halt_req && stopped_reg)
                stopped_reg <= 1'b0; // RULE20
        end
    end
    assign soft_start_src_on = ss_active_reg; // RULE8 RULE9
    // limit judged in off-time only, like the stop level
    logic ss_limit_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            ss_limit_reg <= 1'b0;
        else if (!boost_gate_out)
            ss_limit_reg <= cmp.cs_above_ss_max; // RULE10 RULE11
    end
    assign soft_start_limit = ss_limit_reg && ss_active_reg; // RULE10

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    logic aw_got_reg, w_got_reg;
    logic [7:0] aw_addr_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    assign s_awready = !aw_got_reg && !s_bvalid;
    assign s_wready = !w_got_reg && !s_bvalid;
    assign s_arready = !s_rvalid;
    wire do_write = aw_got_reg && w_got_reg && !s_bvalid;
    wire wr_ctrl = aw_addr_reg == ADDR_CTRL;
    wire wr_ontime = aw_addr_reg == ADDR_ONTIME;
    wire wr_minoff = aw_addr_reg == ADDR_MINOFF;
    wire wr_minper = aw_addr_reg == ADDR_MINPER;
    wire wr_blank = aw_addr_reg == ADDR_BLANK;
    wire wr_hit = wr_ctrl || wr_ontime || wr_minoff || wr_minper || wr_blank;
    wire [15:0] wr_lo = {w_strb_reg[1] ? w_data_reg[15:8] : 8'h00,
        w_strb_reg[0] ? w_data_reg[7:0] : 8'h00};
    wire [31:0] status_word = {20'h00000, state_reg, 1'b0, stopped_reg,
        ss_active_reg, cmp.boost_above_ovp, scp_ok_reg, uvp_reg, burst_reg, boost_gate_out};
    wire [31:0] rd_word = (s_araddr == ADDR_CTRL) ? {30'h00000000, ctrl_reg} :
        (s_araddr == ADDR_STATUS) ? status_word :
        (s_araddr == ADDR_ONTIME) ? {16'h0000, ontime_max_reg} :
        (s_araddr == ADDR_MINOFF) ? {16'h0000, minoff_reg} :
        (s_araddr == ADDR_MINPER) ? {16'h0000, minper_reg} :
        (s_araddr == ADDR_BLANK) ? {16'h0000, blank_reg} : 32'h00000000;
    wire rd_hit = s_araddr == ADDR_CTRL || s_araddr == ADDR_STATUS ||
        s_araddr == ADDR_ONTIME || s_araddr == ADDR_MINOFF ||
        s_araddr == ADDR_MINPER || s_araddr == ADDR_BLANK;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            aw_got_reg <= 1'b0;
            w_got_reg <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg <= '0;
            w_strb_reg <= '0;
            s_bvalid <= 1'b0;
            s_bresp <= RESP_OKAY;
            s_rvalid <= 1'b0;
            s_rdata <= '0;
            s_rresp <= RESP_OKAY;
            ctrl_reg <= '0;
            ontime_max_reg <= ONTIME_MAX_RST;
            minoff_reg <= MINOFF_RST;
            minper_reg <= MINPER_RST;
            blank_reg <= BLANK_RST;
        end else begin
            if (s_awvalid && s_awready) begin
                aw_got_reg <= 1'b1;
                aw_addr_reg <= s_awaddr;
            end
            if (s_wvalid && s_wready) begin
                w_got_reg <= 1'b1;
                w_data_reg <= s_wdata;
                w_strb_reg <= s_wstrb;
            end
            if (do_write) begin
                aw_got_reg <= 1'b0;
                w_got_reg <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
                if (wr_ctrl && w_strb_reg[0])
                    ctrl_reg <= w_data_reg[1:0];
                if (wr_ontime)
                    ontime_max_reg <= wr_lo;
                if (wr_minoff)
                    minoff_reg <= wr_lo;
                if (wr_minper)
                    minper_reg <= wr_lo;
                if (wr_blank)
                    blank_reg <= wr_lo;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
            end
            if (s_arvalid && s_arready) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_word;
                s_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
            end
        end
    end

endmodule : bps_sequencer

`default_nettype wire

// *** dv/bps_sequencer_props.sv ***
`default_nettype none

module bps_sequencer_props
    import bps_pkg::*;
#(
    parameter int MAG_TO_CYC = MAG_TIMEOUT_CYC,
    parameter int VREC_TO_CYC = VREC_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // watched ports
    input wire bps_cmp_t cmp_in,
    input wire logic boost_gate_out,
    input wire logic soft_start_src_on,
    input wire logic soft_start_limit
);
    // ----------------------------------------
    // cycle counters
    // ----------------------------------------
    // limits assume the reset values of the timing registers
    logic [15:0] on_len;
    logic [15:0] off_len;
    logic [15:0] per_len;
    logic gate_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            on_len <= 16'h0000;
            off_len <= 16'hFFFF;
            per_len <= 16'hFFFF;
            gate_q <= 1'b0;
        end else begin
            on_len <= boost_gate_out ? on_len + 16'h0001 : 16'h0000;
            off_len <= boost_gate_out ? 16'h0000 : off_len + {15'h0000, ~&off_len};
            per_len <= (boost_gate_out && !gate_q) ? 16'h0001 : per_len + {15'h0000, ~&per_len};
            gate_q <= boost_gate_out;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_demag_hold: assert property (
        cmp_in.aux_below_demag [*4] |=> !$rose(boost_gate_out)) else $error("gate rose in demag");
    a_uvp_stop: assert property (
        cmp_in.mains_below_uvp [*4] |=> !boost_gate_out) else $error("gate on in undervoltage");
    a_ovp_block: assert property (
        cmp_in.boost_above_ovp [*4] |=> !boost_gate_out) else $error("gate on in overvoltage");
    a_scp_block: assert property (
        !cmp_in.boost_above_scp [*4] |=> !boost_gate_out) else $error("gate on below short level");
    a_zero_ontime: assert property (
        cmp_in.comp_at_zero [*4] |=> !$rose(boost_gate_out)) else $error("gate rose at zero on-time");
    a_ocr_end: assert property (
        (on_len > 16'h0040 && cmp_in.cs_above_ocr) [*3] |=> !boost_gate_out)
        else $error("on-time kept past overcurrent");
    a_blank_hold: assert property (
        $fell(boost_gate_out) |-> on_len > BLANK_RST) else $error("on-time cut in blanking");
    a_min_off: assert property (
        $rose(boost_gate_out) |-> off_len >= MINOFF_RST) else $error("off-time too short");
    a_freq_cap: assert property (
        $rose(boost_gate_out) |-> per_len >= MINPER_RST) else $error("period too short");
    a_ss_limit: assert property (
        (soft_start_src_on && cmp_in.cs_above_ss_max) [*4] |=> soft_start_limit)
        else $error("soft-start source not limiting");

    c_gate_on: cover property ($rose(boost_gate_out));
    c_ss_off: cover property ($fell(soft_start_src_on));
    c_burst_src: cover property (cmp_in.out_below_burst && soft_start_src_on);
endmodule : bps_sequencer_props

bind bps_sequencer bps_sequencer_props #(
    .MAG_TO_CYC(MAG_TO_CYC),
    .VREC_TO_CYC(VREC_TO_CYC)
) u_props (
    .clk(clk),
    .rst(rst),
    .cmp_in(cmp_in),
    .boost_gate_out(boost_gate_out),
    .soft_start_src_on(soft_start_src_on),
    .soft_start_limit(soft_start_limit)
);

`default_nettype wire

// *** dv/bps_power_stage.sv ***
`default_nettype none

module bps_power_stage #(
    parameter int DEMAG_CYC = 200,
    parameter int OCR_AT = 80
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // gate and stage mode
    input wire logic gate,
    input wire logic [1:0] mode,
    input wire logic ocr_en,
    // comparator view
    output logic aux_below_demag,
    output logic aux_top,
    output logic cs_above_ocr
);
    // ----------------------------------------
    // inductor and ringing model
    // ----------------------------------------
    // mode 0 rings, 1 no ringing, 2 never magnetized
    logic [15:0] t_reg;
    logic [15:0] u_reg;
    int ring;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            t_reg <= 16'hFFFF;
            u_reg <= 16'h0000;
        end else begin
            t_reg <= gate ? 16'h0000 : t_reg + {15'h0000, ~&t_reg};
            u_reg <= gate ? u_reg + 16'h0001 : 16'h0000;
        end
    end
    assign ring = int'(t_reg) - DEMAG_CYC - 20;
    assign aux_below_demag = !gate && mode != 2'h2 && int'(t_reg) < DEMAG_CYC;
    // ringing decays, so tops stop after a while
    assign aux_top = !gate && mode == 2'h0 && ring >= 0 && ring < 2000 && ring % 25 < 2;
    // drain discharge spike right after turn-on
    assign cs_above_ocr = gate && ((u_reg > 16'h0001 && u_reg < 16'h0006)
        || (ocr_en && int'(u_reg) >= OCR_AT));
endmodule : bps_power_stage

`default_nettype wire

// *** dv/tb_boost_pfc_switch_sequencer.sv ***
`default_nettype none

module tb_boost_pfc_switch_sequencer
    import bps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam int MAG_TO = 300;
    localparam int VREC_TO = 150;
    localparam int DEMAG = 200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    bps_cmp_t drv = '0;
    bps_cmp_t cmp;
    logic [1:0] mode = 2'h0;
    logic ocr_en = 1'b0;
    logic [15:0] comp = 16'h0000;
    logic p_demag, p_top, p_ocr, gate, src_on, src_lim;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    int num_errors = 0;
    int check_count = 0;
    int cycles = 0;

    always #2.5 clk = ~clk;
    always_comb begin
        cmp = drv;
        cmp.aux_below_demag = p_demag;
        cmp.aux_top = p_top;
        cmp.cs_above_ocr = p_ocr;
    end

    bps_sequencer #(.MAG_TO_CYC(MAG_TO), .VREC_TO_CYC(VREC_TO)) dut (
        .clk(clk), .rst(rst), .cmp_in(cmp), .loop_compensation(comp),
        .boost_gate_out(gate), .soft_start_src_on(src_on), .soft_start_limit(src_lim),
        .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp),
        .s_bvalid(bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
        .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(rready));

    bps_power_stage #(.DEMAG_CYC(DEMAG)) u_stage (
        .clk(clk), .rst(rst), .gate(gate), .mode(mode), .ocr_en(ocr_en),
        .aux_below_demag(p_demag), .aux_top(p_top), .cs_above_ocr(p_ocr));

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [63:0] got, input logic [63:0] exp, input string msg);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : check

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        r = bresp;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
    endtask : axi_rd

    task automatic rises(input int cyc, output int n);
        logic g;
        n = 0;
        g = gate;
        repeat (cyc) begin
            @(posedge clk);
            if (gate === 1'b1 && g !== 1'b1) n++;
            g = gate;
        end
    endtask : rises

    // off-time of the next complete switching cycle
    task automatic off_time(output int n);
        n = 0;
        while (gate !== 1'b1) @(posedge clk);
        while (gate === 1'b1) @(posedge clk);
        while (gate !== 1'b1) begin
            @(posedge clk);
            n++;
        end
    endtask : off_time

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        check(src_on, 1, "ss source at reset");
        drv.cs_above_ss_max <= 1'b1;
        repeat (6) @(posedge clk);
        check(src_lim, 1, "ss limit");
        drv.cs_above_ss_max <= 1'b0;
        axi_rd(ADDR_MINOFF, d, r);
        check(d, MINOFF_RST, "min off reg");
        axi_rd(ADDR_MINPER, d, r);
        check(d, MINPER_RST, "min period reg");
        axi_rd(ADDR_BLANK, d, r);
        check(d, BLANK_RST, "blank reg");
        axi_rd(8'h3C, d, r);
        check({d, r}, {32'h0, RESP_SLVERR}, "unmapped read");
        axi_wr(8'h3C, 32'h1, r);
        check(r, RESP_SLVERR, "unmapped write");
    endtask : t_regs

    task automatic t_start();
        int n;
        logic [1:0] r;
        axi_wr(ADDR_CTRL, 32'h1, r);
        rises(400, n);
        check(n, 0, "start without boost");
        drv.boost_above_scp <= 1'b1;
        rises(400, n);
        check(n, 0, "start without mains");
        drv.mains_above_start <= 1'b1;
        rises(2000, n);
        check(n > 0, 1, "started");
        check(src_on, 1, "ss source in start-up");
        axi_wr(ADDR_CTRL, 32'h3, r);
        repeat (4) @(posedge clk);
        check(src_on, 0, "ss source after start-up");
    endtask : t_start

    task automatic t_valley();
        int n;
        repeat (2) off_time(n);
        check(n >= DEMAG + 20 && n <= DEMAG + 28, 1, "valley turn-on");
        ocr_en <= 1'b1;
        repeat (2) off_time(n);
        check(n >= 316 && n <= 330, 1, "skip to later valley");
        ocr_en <= 1'b0;
        comp <= 16'h0064;
        repeat (2) off_time(n);
        check(n >= 316 && n <= 330, 1, "shorter on-time");
        comp <= 16'h0000;
        mode <= 2'h1;
        repeat (2) off_time(n);
        check(n >= DEMAG + VREC_TO && n <= DEMAG + VREC_TO + 8, 1, "valley timeout");
        mode <= 2'h2;
        repeat (2) off_time(n);
        check(n >= MAG_TO && n <= MAG_TO + 8, 1, "magnetize timeout");
        mode <= 2'h0;
    endtask : t_valley

    // soft-stop level raised only inside an on-time must not stop switching
    task automatic t_on_glitch();
        int n;
        while (gate !== 1'b1) @(posedge clk);
        drv.cs_above_soft_stop <= 1'b1;
        repeat (20) @(posedge clk);
        drv.cs_above_soft_stop <= 1'b0;
        rises(1500, n);
        check(n > 0, 1, "on-time level ignored");
    endtask : t_on_glitch

    task automatic stop_test(input logic [10:0] m, output logic s, output logic q,
                             output logic ss);
        int n;
        while (gate !== 1'b1) @(posedge clk);
        while (gate === 1'b1) @(posedge clk);
        drv <= drv ^ m;
        rises(600, n);
        s = (n == 0);
        ss = src_on;
        drv <= drv ^ m;
        @(posedge clk);
        drv.out_below_burst <= 1'b1;
        repeat (20) @(posedge clk);
        drv.out_below_burst <= 1'b0;
        rises(2000, n);
        q = (n > 0);
    endtask : stop_test

    task automatic t_protect();
        logic s, q, ss;
        stop_test(11'h030, s, q, ss);
        check(s, 1, "mains stop");
        check(q, 1, "mains restart");
        stop_test(11'h008, s, q, ss);
        check({s, q}, 2'h3, "overvoltage");
        stop_test(11'h004, s, q, ss);
        check({s, q}, 2'h3, "short level");
        stop_test(11'h002, s, q, ss);
        check({s, q}, 2'h3, "zero on-time");
        stop_test(11'h040, s, q, ss);
        check(s, 1, "soft stop");
        stop_test(11'h041, s, q, ss);
        check(ss, 1, "burst source on");
        check({s, q}, 2'h3, "burst");
    endtask : t_protect

    // ----------------------------------------
    // main
    // ----------------------------------------
    always @(posedge clk) begin
        cycles++;
        if (cycles > 60000) begin
            num_errors++;
            print_verdict();
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_start();
        t_valley();
        t_on_glitch();
        t_protect();
        print_verdict();
    end
endmodule : tb_boost_pfc_switch_sequencer

`default_nettype wire
